// ### design/sld_host.sv
module sld_host
  import sld_pkg::*;
#(
  parameter int N = SLD_CHANNELS,
  parameter int D = SLD_FIFO_DEPTH
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_word_valid,
  output logic              o_word_ready,
  input  wire logic [N-1:0] i_word,
  input  wire logic         i_blank,
  output logic              o_busy,
  output logic              o_ser_back,
  sld_link_if.host          link
);

  if (N < 2 || N > 255) begin : g_chk
    $error("sld_host width out of counter range");
  end

  // ----------------------------------------------------------------
  // Word buffer
  // ----------------------------------------------------------------
  logic         fifo_valid;
  logic [N-1:0] fifo_data;
  logic         fifo_pop;

  sld_fifo #(.W(N), .D(D)) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_word_valid),
    .o_in_ready  (o_word_ready),
    .i_in_data   (i_word),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_data)
  );

  // ----------------------------------------------------------------
  // Sequencer; shift clock divided down from the reference
  // ----------------------------------------------------------------
  sld_host_state_t      state_q;
  sld_host_state_t      state_d;
  logic [SLD_CNT_W-1:0] tmr_q;
  logic [SLD_CNT_W-1:0] tmr_d;
  logic [SLD_CNT_W-1:0] bit_q;
  logic [SLD_CNT_W-1:0] bit_d;
  logic [N-1:0]         sh_q;
  logic [N-1:0]         sh_d;
  logic                 back_m_q;
  logic                 back_q;

  wire tmr_done = (tmr_q == '0);
  wire last_bit = (bit_q == SLD_CNT_W'(N - 1));

  always_comb
  begin
    state_d  = state_q;
    tmr_d    = tmr_done ? '0 : tmr_q - SLD_CNT_W'(1);
    bit_d    = bit_q;
    sh_d     = sh_q;
    fifo_pop = 1'b0;
    case (state_q)
      SLD_IDLE:
      begin
        if (fifo_valid)
        begin
          sh_d     = fifo_data;
          bit_d    = '0;
          fifo_pop = 1'b1;
          tmr_d    = SLD_CNT_W'(SLD_CLK_HALF_CYC - 1);
          state_d  = SLD_LOW;
        end
      end
      // low and high at least 150 ns
      SLD_LOW:
      begin
        if (tmr_done)
        begin
          tmr_d   = SLD_CNT_W'(SLD_CLK_HALF_CYC - 1);
          state_d = SLD_HIGH;
        end
      end
      SLD_HIGH:
      begin
        if (tmr_done)
        begin
          sh_d  = {sh_q[N-2:0], 1'b0};
          bit_d = bit_q + SLD_CNT_W'(1);
          if (last_bit)
          begin
            tmr_d   = SLD_CNT_W'(SLD_GAP_CYC - 1);
            state_d = SLD_GAP;
          end
          else
          begin
            tmr_d   = SLD_CNT_W'(SLD_CLK_HALF_CYC - 1);
            state_d = SLD_LOW;
          end
        end
      end
      SLD_GAP:
      begin
        if (tmr_done)
        begin
          tmr_d   = SLD_CNT_W'(SLD_LOAD_CYC - 1);
          state_d = SLD_LOAD;
        end
      end
      SLD_LOAD:
      begin
        if (tmr_done)
        begin
          state_d = SLD_POP;
        end
      end
      SLD_POP:
      begin
        state_d = SLD_IDLE;
      end
      default:
      begin
        state_d = SLD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      state_q <= SLD_IDLE;
      tmr_q   <= '0;
      bit_q   <= '0;
      sh_q    <= '0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
    end
  end

  // Serial echo from the chain is foreign timing
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      back_m_q <= 1'b0;
      back_q   <= 1'b0;
    end
    else
    begin
      back_m_q <= link.ser_out;
      back_q   <= back_m_q;
    end
  end

  // MSB first, so bit N-1 ends in the last stage
  assign link.shift_clk  = (state_q == SLD_HIGH);
  assign link.ser_data   = sh_q[N-1];
  // Load only in its own state keeps latches steady while shifting
  assign link.latch_load = (state_q == SLD_LOAD);
  assign link.out_blank  = i_blank;
  assign o_busy          = (state_q != SLD_IDLE);
  assign o_ser_back      = back_q;

endmodule // sld_host

// ### design/sld_pkg.sv
package sld_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int SLD_CHANNELS      = 32;
  localparam int SLD_FIFO_DEPTH    = 16;

  // ----------------------------------------------------------------
  // Timing, host side
  // ----------------------------------------------------------------
  localparam int SLD_REF_PERIOD_NS = 10;
  localparam int SLD_CLK_MIN_NS    = 150;
  localparam int SLD_GAP_MIN_NS    = 300;
  localparam int SLD_LOAD_MIN_NS   = 100;
  // Least times round up
  localparam int SLD_CLK_HALF_CYC  = (SLD_CLK_MIN_NS + SLD_REF_PERIOD_NS - 1) / SLD_REF_PERIOD_NS;
  localparam int SLD_GAP_CYC       = (SLD_GAP_MIN_NS + SLD_REF_PERIOD_NS - 1) / SLD_REF_PERIOD_NS;
  localparam int SLD_LOAD_CYC      = (SLD_LOAD_MIN_NS + SLD_REF_PERIOD_NS - 1) / SLD_REF_PERIOD_NS;
  localparam int SLD_CNT_W         = 8;

  // ----------------------------------------------------------------
  // Host states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    SLD_IDLE  = 6'h01,
    SLD_LOW   = 6'h02,
    SLD_HIGH  = 6'h04,
    SLD_GAP   = 6'h08,
    SLD_LOAD  = 6'h10,
    SLD_POP   = 6'h20
  } sld_host_state_t;

endpackage

// ### design/sld_link_if.sv
interface sld_link_if;
  logic shift_clk;
  logic ser_data;
  logic latch_load;
  logic out_blank;
  logic ser_out;

  modport host (
    output shift_clk,
    output ser_data,
    output latch_load,
    output out_blank,
    input  ser_out
  );

  modport dev (
    input  shift_clk,
    input  ser_data,
    input  latch_load,
    input  out_blank,
    output ser_out
  );
endinterface

// ### design/sld_device.sv
// Operation
// - Rising shift clock captures serial input
// - Later edges move bits toward output
// - Latch load high makes latches transparent
// - Blank high forces every output low
// - Blank never changes latch contents
// - Blank low drives outputs from latches
// - Host passes blank straight through from i_blank; latches hold while shifting
// - Host waits 300 ns before latch load
// - Host holds latch load 100 ns
// - Host clock pulse 150 ns, max 3.3 MHz
// - Last stage drives serial data output
module sld_device
  import sld_pkg::*;
#(
  parameter int N = SLD_CHANNELS
) (
  input  wire logic         i_sys_rst,
  sld_link_if.dev           link,
  output logic [N-1:0]      o_outputs,
  output logic [N-1:0]      o_latch
);

  if (N < 2) begin : g_chk
    $error("sld_device needs at least two stages");
  end

  // ----------------------------------------------------------------
  // Shift chain, on the link clock
  // ----------------------------------------------------------------
  logic [N-1:0] shift_q;
  logic [N-1:0] shift_d;

  assign shift_d = {shift_q[N-2:0], link.ser_data};

  // No reset on the device: the part itself has none
  always_ff @(posedge link.shift_clk)
  begin
    shift_q <= shift_d;
  end

  assign link.ser_out = shift_q[N-1];

  // ----------------------------------------------------------------
  // Latches, level sensitive as the part is
  // ----------------------------------------------------------------
  // transparent while load high
  always_latch
  begin
    if (link.latch_load)
    begin
      o_latch <= shift_q;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // blank forces low
  assign o_outputs = link.out_blank ? '0 : o_latch;

endmodule // sld_device

// ### design/sld_fifo.sv
module sld_fifo
  import sld_pkg::*;
#(
  parameter int W = SLD_CHANNELS,
  parameter int D = SLD_FIFO_DEPTH
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);

  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("sld_fifo depth must be a power of two");
  end

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;

  wire push  = i_in_valid && o_in_ready;
  wire pop   = o_out_valid && i_out_ready;
  wire empty = (wr_q == rd_q);
  wire full  = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end

endmodule // sld_fifo

// ### test/sld_link_asserts.sv
module sld_link_asserts
  import sld_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        shift_clk,
  input wire logic        latch_load,
  input wire logic        out_blank,
  input wire logic        ser_out,
  input wire logic [31:0] o_outputs,
  input wire logic [31:0] o_latch
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Phase counters, saturating so idle never wraps
  // ----
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic [7:0] lo_d;
  logic [7:0] hi_d;
  logic [7:0] ld_q;
  logic [7:0] ld_d;
  assign lo_d = shift_clk ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
  assign hi_d = !shift_clk ? 8'h00 : hi_q + {7'h00, hi_q != 8'hFF};
  // Load width counted here, a long repetition would be unrolled
  assign ld_d = !latch_load ? 8'h00 : ld_q + {7'h00, ld_q != 8'hFF};
  always_ff @(posedge i_ref_clk)
  begin
    lo_q <= i_sys_rst ? 8'hFF : lo_d;
    hi_q <= i_sys_rst ? 8'h00 : hi_d;
    ld_q <= i_sys_rst ? 8'h00 : ld_d;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ----
  // Properties
  // ----
  a_blank_forces_low: assert property (out_blank |-> o_outputs === 32'h0)
    else $error("outputs not low while blanked");
  a_outputs_follow: assert property (!out_blank |-> o_outputs === o_latch)
    else $error("outputs differ from latches");
  a_latch_transparent: assert property (latch_load |-> o_latch[31] === ser_out)
    else $error("latch not following chain");
  a_latch_hold: assert property (
    !latch_load && !$past(latch_load) |-> o_latch === $past(o_latch))
    else $error("latch moved while closed");
  a_blank_keeps_latch: assert property (
    $changed(out_blank) && !latch_load |-> $stable(o_latch))
    else $error("blank disturbed latches");
  a_chain_moves: assert property ($changed(ser_out) |-> $rose(shift_clk))
    else $error("serial out moved without clock");
  a_load_gap: assert property ($rose(latch_load) |-> lo_q >= 8'h1E)
    else $error("load too soon after clock");
  a_load_width: assert property ($fell(latch_load) |-> ld_q >= 8'h0A)
    else $error("load pulse too short");
  a_clk_phases: assert property ($fell(shift_clk) |-> hi_q >= 8'h0F)
    else $error("clock high phase too short");
  a_clk_low: assert property ($rose(shift_clk) |-> lo_q >= 8'h0F)
    else $error("clock low phase too short");
endmodule // sld_link_asserts

// ### test/serial_latched_output_driver_tb_top.sv
module serial_latched_output_driver_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sld_pkg::*;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        w_valid = 1'b0;
  logic [31:0] w_data  = 32'h0;
  logic        blank   = 1'b0;
  logic        w_ready;
  logic        busy;
  logic        ser_back;
  logic [31:0] outs;
  logic [31:0] lat;
  logic [31:0] seed    = 32'h4;
  logic [31:0] last;
  logic [31:0] exp_q[$];
  int          bad_count = 0;
  int          comparisons = 0;
  int          full_seen = 0;
  always #5 ref_clk = ~ref_clk;
  sld_link_if sld_link_if_i ();
  sld_host sld_host_i (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_word_valid(w_valid),
    .o_word_ready(w_ready), .i_word(w_data), .i_blank(blank), .o_busy(busy),
    .o_ser_back(ser_back), .link(sld_link_if_i.host));
  sld_device sld_device_i (.i_sys_rst(sys_rst), .link(sld_link_if_i.dev), .o_outputs(outs),
    .o_latch(lat));
  sld_link_asserts sld_link_asserts_i (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .shift_clk(sld_link_if_i.shift_clk), .latch_load(sld_link_if_i.latch_load),
    .out_blank(sld_link_if_i.out_blank), .ser_out(sld_link_if_i.ser_out),
    .o_outputs(outs), .o_latch(lat));
  // ----
  // Tasks
  // ----
  task check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d of %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function logic [31:0] xs;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Caller is at a falling edge; valid stays up between words
  task put(input logic [31:0] w);
    w_valid = 1'b1;
    w_data  = w;
    while (w_ready !== 1'b1)
    begin
      full_seen = 1;
      @(negedge ref_clk);
    end
    exp_q.push_back(w);
    last = w;
    @(negedge ref_clk);
  endtask
  // ----
  // Model compare at every load
  // ----
  always @(negedge sld_link_if_i.latch_load)
  begin
    #1;
    if (!sys_rst)
    begin
      check(lat, exp_q[0]);
      check(outs, blank ? 32'h0 : exp_q[0]);
      check({31'h0, sld_link_if_i.ser_out}, {31'h0, exp_q[0][31]});
      void'(exp_q.pop_front());
    end
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    put(32'h0000_0001);
    put(32'h8000_0000);
    repeat (18) put(xs());
    check(32'(full_seen), 32'h1);
    // Latches still loaded, so blank covers the shifting
    // blank while shifting
    blank = 1'b1;
    repeat (2) put(xs());
    w_valid = 1'b0;
    for (int i = 0; i < 40000 && exp_q.size() != 0; i++) @(negedge ref_clk);
    check(32'(exp_q.size()), 32'h0);
    repeat (4) @(negedge ref_clk);
    check({31'h0, busy}, 32'h0);
    check(outs, 32'h0);
    check(lat, last);
    check({31'h0, ser_back}, {31'h0, last[31]});
    blank = 1'b0;
    @(negedge ref_clk);
    check(outs, last);
    check(lat, last);
    give_verdict();
  end
  initial
  begin
    #400000;
    bad_count++;
    give_verdict();
  end
endmodule // serial_latched_output_driver_tb_top
